//--- swre_assertions.sv
// Purpose: port assertions for the word store unit
// Assumes: one clock domain, presetn async active low
// Notes:   bound onto swre_top at the foot of this file
`timescale 1ns/1ps
module swre_assertions
    import swre_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_data,
    input wire logic [3:0]  mem_be,
    input wire logic        mem_ack,
    input wire logic        base_wb,
    input wire logic [31:0] base_wb_data,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // a misaligned store leaves as two parts: the lower lanes go first
    sequence s_first_part;
        mem_req && mem_ack && mem_be inside {4'h7, 4'h3, 4'h1};
    endsequence
    sequence s_second_part;
        mem_req && mem_be == ~$past(mem_be) && mem_addr == $past(mem_addr) + 32'h4;
    endsequence
    sequence s_last_part;
        mem_req && mem_ack && mem_be inside {4'hf, 4'he, 4'hc, 4'h8};
    endsequence

    a_err_unmapped: assert property (
        psel && penable && (paddr > REG_IRQ_MK || paddr[1:0] != 2'b00) |-> pslverr)
        else $error("no slave error on a bad address");
    a_err_mapped: assert property (
        psel && penable && paddr <= REG_IRQ_MK && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("slave error on a mapped address");
    a_req_held: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_data)
            && $stable(mem_be))
        else $error("store request changed before acceptance");
    a_part_aligned: assert property (
        mem_req |-> mem_addr[1:0] == 2'b00 && mem_be != 4'h0)
        else $error("store part not word aligned");
    a_split_pair: assert property (s_first_part |=> s_second_part)
        else $error("second part of split store wrong");
    a_last_release: assert property (s_last_part |=> !mem_req)
        else $error("request stayed up after last part");
    a_update_addr: assert property (
        base_wb |=> mem_req && mem_addr == ($past(base_wb_data) & 32'hffff_fffc))
        else $error("written back base differs from store address");
    a_mask_off: assert property (
        psel && penable && pwrite && paddr == REG_IRQ_MK && pwdata[5:0] == 6'h00 |=> !irq)
        else $error("interrupt high with all sources masked");
endmodule : swre_assertions

bind swre_top swre_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_be(mem_be), .mem_ack(mem_ack),
    .base_wb(base_wb), .base_wb_data(base_wb_data), .irq(irq)
);

//--- swre_decode.sv
// Purpose: decode one store instruction and form its effective address
// Assumes: operand values are stable while decode is read
// Notes:   purely combinational
`timescale 1ns/1ps
module swre_decode
    import swre_pkg::*;
(
    input  wire logic [31:0]     insn,
    input  wire logic [31:0]     base_val,
    input  wire logic [31:0]     index_val,
    output swre_pkg::swre_op_t   op,
    output logic [31:0]          effective_addr,
    output logic                 invalid_form
);
    logic [5:0]  opcd;
    logic [9:0]  xo;
    logic [4:0]  base_gpr;
    logic [31:0] base_or_zero;
    logic [31:0] disp;

    assign opcd     = insn[OPCD_LSB +: 6];
    assign xo       = insn[XO_LSB +: 10];
    assign base_gpr = insn[BASE_LSB +: 5];
    // base reads as zero for field 0
    assign base_or_zero = (base_gpr == 5'h00) ? 32'h0000_0000 : base_val;
    assign disp = {{16{insn[15]}}, insn[15:0]};

    always_comb
    begin
        op = SWRE_OP_NONE;
        if (opcd == OPC_STW)
            op = SWRE_OP_STW;
        else if (opcd == OPC_STW_UPD)
            op = SWRE_OP_STW_UPD;
        else if (opcd == OPC_EXT && xo == XO_STW_IDX)
            op = SWRE_OP_STW_IDX;
        else if (opcd == OPC_EXT && xo == XO_STWUX)
            op = SWRE_OP_STWUX;
        else if (opcd == OPC_EXT && xo == XO_STWBRX)
            op = SWRE_OP_STWBRX;
        else if (opcd == OPC_EXT && xo == XO_STWCX)
            op = SWRE_OP_STWCX;
    end

    always_comb
    begin
        if (op == SWRE_OP_STW || op == SWRE_OP_STW_UPD)
            effective_addr = base_or_zero + disp;
        else
            effective_addr = base_or_zero + index_val;
    end

    // update forms with base 0, zero bit 0 on the conditional store, unknown opcodes
    always_comb
    begin
        invalid_form = 1'b0;
        if (op == SWRE_OP_NONE)
            invalid_form = 1'b1;
        else if ((op == SWRE_OP_STW_UPD || op == SWRE_OP_STWUX) && base_gpr == 5'h00)
            invalid_form = 1'b1;
        else if (op == SWRE_OP_STWCX && insn[0] == 1'b0)
            invalid_form = 1'b1;
    end
endmodule : swre_decode

//--- swre_mem_model.sv
// Purpose: storage partner that accepts each store part with mem_ack
// Assumes: one part accepted per handshake, latency set by the bench
// Notes:   never acks without a pending request
`timescale 1ns/1ps
module swre_mem_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       mem_req,
    input  wire logic [7:0] delay_cyc,
    output logic            mem_ack
);
    logic [7:0] wait_cnt;

    // split stores arrive as separate aligned parts, each acked alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_ack  <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else if (mem_ack || !mem_req)
        begin
            mem_ack  <= 1'b0;
            wait_cnt <= 8'h00;
        end
        else if (wait_cnt >= delay_cyc)
            mem_ack <= 1'b1;
        else
            wait_cnt <= wait_cnt + 8'h01;
    end
endmodule : swre_mem_model

//--- swre_pkg.sv
// Purpose: shared constants and types for the word store execution unit
// Assumes: 32-bit instruction word, bits numbered from bit 0 = lsb
// Notes:   instruction fields are taken at the opcode positions below
package swre_pkg;

    // ----------------------------------------------------------------------
    // instruction fields (lsb positions, counted from bit 0 = lsb)
    // ----------------------------------------------------------------------
    localparam int unsigned OPCD_LSB   = 26;
    localparam int unsigned SRC_LSB    = 21;
    localparam int unsigned BASE_LSB   = 16;
    localparam int unsigned INDEX_LSB  = 11;
    localparam int unsigned XO_LSB     = 1;

    localparam logic [5:0] OPC_EXT     = 6'h1f;
    localparam logic [5:0] OPC_STW     = 6'h24;
    localparam logic [5:0] OPC_STW_UPD = 6'h25;
    localparam logic [9:0] XO_STW_IDX  = 10'h097;
    localparam logic [9:0] XO_STWUX    = 10'h0b7;
    localparam logic [9:0] XO_STWBRX   = 10'h296;
    localparam logic [9:0] XO_STWCX    = 10'h096;

    // ----------------------------------------------------------------------
    // condition field bit positions (bit 0 is lsb of the 4-bit field)
    // ----------------------------------------------------------------------
    localparam int unsigned CR_EQ_POS  = 1;
    localparam int unsigned CR_SO_POS  = 0;

    // ----------------------------------------------------------------------
    // apb register map
    // ----------------------------------------------------------------------
    localparam logic [7:0]  REG_INSN   = 8'h00;
    localparam logic [7:0]  REG_SRC    = 8'h04;
    localparam logic [7:0]  REG_BASE   = 8'h08;
    localparam logic [7:0]  REG_INDEX  = 8'h0c;
    localparam logic [7:0]  REG_CTRL   = 8'h10;
    localparam logic [7:0]  REG_STAT   = 8'h14;
    localparam logic [7:0]  REG_ADDR   = 8'h18;
    localparam logic [7:0]  REG_WDATA  = 8'h1c;
    localparam logic [7:0]  REG_IRQ_ST = 8'h20;
    localparam logic [7:0]  REG_IRQ_MK = 8'h24;

    // ctrl bits
    localparam int unsigned CTRL_GO     = 0;
    localparam int unsigned CTRL_RESV   = 1;
    localparam int unsigned CTRL_ALIGN  = 2;
    localparam int unsigned CTRL_LE     = 3;
    localparam int unsigned CTRL_SO     = 4;
    localparam int unsigned CTRL_TMISS  = 5;
    localparam int unsigned CTRL_DSI    = 6;
    localparam int unsigned CTRL_DBG    = 7;

    // irq status bits
    localparam int unsigned IRQ_DONE    = 0;
    localparam int unsigned IRQ_ALIGN   = 1;
    localparam int unsigned IRQ_TMISS   = 2;
    localparam int unsigned IRQ_DSI     = 3;
    localparam int unsigned IRQ_DBG     = 4;
    localparam int unsigned IRQ_INVAL   = 5;
    localparam int unsigned IRQ_W       = 6;

    localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
    localparam int unsigned TIMEOUT_CYC = 8;

    typedef enum logic [2:0] {
        SWRE_OP_NONE, SWRE_OP_STW, SWRE_OP_STW_UPD, SWRE_OP_STW_IDX,
        SWRE_OP_STWUX, SWRE_OP_STWBRX, SWRE_OP_STWCX
    } swre_op_t;

endpackage : swre_pkg

//--- swre_top.sv
// Purpose: word store execution unit with reservation handling, apb control
// Assumes: storage subsystem answers each write with mem_ack
// Notes:   software loads operands, sets go; results read back over apb
//
// Overview of operation
// - indexed forms add the index register to a base that is zero when the base field is 0.
// - the byte-reversed store writes the word in order opposite to the page endian attribute.
// - indexed non-conditional stores with bit 0 set leave the condition field undefined.
// - a conditional store with the reservation set writes the word and clears the reservation.
// - a conditional store with the reservation clear performs no memory write.
// - a conditional store sets the condition field to 0,0,written,summary overflow.
// - every valid-form conditional store clears the reservation in the cycle that go is taken.
// - only the reservation-setting load sets the reservation bit.
// - a failing conditional store raises no storage or debug interrupt.
// - a translation miss during a conditional store always raises its interrupt.
// - with forced alignment on, a misaligned conditional store always raises alignment.
// - with forced alignment off, misaligned stores run, possibly split into aligned parts.
// - displacement forms sign-extend 16 bits to 32 and add the zero-or-base value.
// - update forms write the address back to the base register; base field 0 is invalid.
// - plain, indexed and update stores write all four bytes in default order.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module swre_top
    import swre_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        resv_load,
    output logic             mem_req,
    output logic [31:0]      mem_addr,
    output logic [31:0]      mem_data,
    output logic [3:0]       mem_be,
    input  wire logic        mem_ack,
    output logic             base_wb,
    output logic [31:0]      base_wb_data,
    output logic             irq
);
    // ----------------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------------
    logic [31:0] insn;
    logic [31:0] source_gpr;
    logic [31:0] base_gpr;
    logic [31:0] index_gpr;
    logic [7:0]  ctrl;
    logic        reservation;
    logic [3:0]  cond_field_zero;
    logic        busy;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic [1:0]  parts_left;
    logic        fault_now;

    swre_op_t    op;
    logic [31:0] effective_addr;
    logic        invalid_form;

    swre_decode u_dec (
        .insn           (insn),
        .base_val       (base_gpr),
        .index_val      (index_gpr),
        .op             (op),
        .effective_addr (effective_addr),
        .invalid_form   (invalid_form)
    );

    // ----------------------------------------------------------------------
    // apb access
    // ----------------------------------------------------------------------
    logic wr_en;
    logic rd_hit;
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a <= REG_IRQ_MK) && (a[1:0] == 2'b00);
    endfunction : addr_mapped

    assign rd_hit  = addr_mapped(paddr);
    assign pslverr = psel && penable && !rd_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            insn       <= RST_ZERO;
            source_gpr <= RST_ZERO;
            index_gpr  <= RST_ZERO;
            irq_mask   <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == REG_INSN)
                insn <= pwdata;
            else if (paddr == REG_SRC)
                source_gpr <= pwdata;
            else if (paddr == REG_INDEX)
                index_gpr <= pwdata;
            else if (paddr == REG_IRQ_MK)
                irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    // ctrl: go self-clears at start; other bits held
    logic start;
    assign start = ctrl[CTRL_GO] && !busy;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= 8'h00;
        else if (wr_en && paddr == REG_CTRL)
            ctrl <= pwdata[7:0];
        else if (start)
            ctrl[CTRL_GO] <= 1'b0;
    end

    // base register: written by software or by update-form writeback
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            base_gpr <= RST_ZERO;
        else if (start && !invalid_form && !fault_now
                 && (op == SWRE_OP_STW_UPD || op == SWRE_OP_STWUX))
            base_gpr <= effective_addr;
        else if (wr_en && paddr == REG_BASE)
            base_gpr <= pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= RST_ZERO;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == REG_INSN)
                prdata <= insn;
            else if (paddr == REG_SRC)
                prdata <= source_gpr;
            else if (paddr == REG_BASE)
                prdata <= base_gpr;
            else if (paddr == REG_INDEX)
                prdata <= index_gpr;
            else if (paddr == REG_CTRL)
                prdata <= {24'h0, ctrl};
            else if (paddr == REG_STAT)
                prdata <= {26'h0, busy, reservation, cond_field_zero};
            else if (paddr == REG_ADDR)
                prdata <= addr_q;
            else if (paddr == REG_WDATA)
                prdata <= wdata_q;
            else if (paddr == REG_IRQ_ST)
                prdata <= {26'h0, irq_stat};
            else if (paddr == REG_IRQ_MK)
                prdata <= {26'h0, irq_mask};
            else
                prdata <= RST_ZERO;
        end
    end

    // ----------------------------------------------------------------------
    // execution
    // ----------------------------------------------------------------------
    logic is_cond;
    logic misaligned;
    logic cond_ok;
    logic do_write;
    logic [31:0] swapped;

    assign is_cond    = (op == SWRE_OP_STWCX);
    assign misaligned = (effective_addr[1:0] != 2'b00);
    assign cond_ok    = !is_cond || reservation;
    // alignment and translation miss fire regardless of the reservation
    assign fault_now  = (ctrl[CTRL_ALIGN] && misaligned && is_cond)
                      || ctrl[CTRL_TMISS]
                      || (cond_ok && (ctrl[CTRL_DSI] || ctrl[CTRL_DBG]));
    assign do_write   = start && !invalid_form && !fault_now && cond_ok;
    assign swapped    = {source_gpr[7:0], source_gpr[15:8],
                         source_gpr[23:16], source_gpr[31:24]};

    always_comb
    begin
        irq_set = '0;
        if (start)
        begin
            irq_set[IRQ_DONE]  = 1'b1;
            irq_set[IRQ_INVAL] = invalid_form;
            irq_set[IRQ_ALIGN] = ctrl[CTRL_ALIGN] && misaligned && is_cond;
            irq_set[IRQ_TMISS] = ctrl[CTRL_TMISS];
            irq_set[IRQ_DSI]   = cond_ok && ctrl[CTRL_DSI];
            irq_set[IRQ_DBG]   = cond_ok && ctrl[CTRL_DBG];
        end
    end

    // the memory port sees big-endian bytes; little-endian pages get swapped data, except the byte-reversed store, which swaps on big-endian pages
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_q     <= RST_ZERO;
            wdata_q    <= RST_ZERO;
            mem_be     <= 4'h0;
            parts_left <= 2'd0;
        end
        else if (do_write)
        begin
            // the port only carries word addresses; lanes pick the bytes
            addr_q <= {effective_addr[31:2], 2'b00};
            if (op == SWRE_OP_STWBRX)
                wdata_q <= ctrl[CTRL_LE] ? source_gpr : swapped;
            else
                wdata_q <= ctrl[CTRL_LE] ? swapped : source_gpr;
            // misaligned words go out as two aligned parts
            mem_be     <= 4'hf >> effective_addr[1:0];
            parts_left <= misaligned ? 2'd2 : 2'd1;
        end
        else if (mem_req && mem_ack)
        begin
            addr_q     <= {addr_q[31:2] + 30'h1, 2'b00};
            mem_be     <= ~mem_be;
            parts_left <= parts_left - 2'd1;
        end
    end

    assign mem_req  = busy;
    assign mem_addr = addr_q;
    assign mem_data = wdata_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy <= 1'b0;
        else if (do_write)
            busy <= 1'b1;
        else if (mem_ack && parts_left == 2'd1)
            busy <= 1'b0;
    end

    // reservation: set only by the reserving load, cleared by any valid-form conditional store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            reservation <= 1'b0;
        else if (start && is_cond && !invalid_form)
            reservation <= 1'b0;
        else if (resv_load)
            reservation <= 1'b1;
    end

    // condition field: only the conditional store defines it; indexed forms leave it alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cond_field_zero <= 4'h0;
        else if (start && is_cond && !invalid_form && !fault_now)
            cond_field_zero <= {2'b00, reservation, ctrl[CTRL_SO]};
    end

    // ----------------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat <= '0;
        else if (wr_en && paddr == REG_IRQ_ST)
            irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_set;
        else
            irq_stat <= irq_stat | irq_set;
    end

    assign irq = |(irq_stat & irq_mask);

    assign base_wb      = start && !invalid_form && !fault_now
                          && (op == SWRE_OP_STW_UPD || op == SWRE_OP_STWUX);
    assign base_wb_data = effective_addr;

endmodule : swre_top

//--- tb.sv
// Purpose: self-checking bench for the word store unit
// Assumes: apb master here, storage partner model on the far side
// Notes:   expected stores queue up and are matched as they leave
`timescale 1ns/1ps
module tb;
    import swre_pkg::*;

    typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] dm; logic [3:0] be;} swre_exp_t;

    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h0;
    logic        resv_load = 1'b0;
    logic [7:0]  delay_cyc = 8'h00;
    logic [5:0]  mk        = 6'h00;
    logic [31:0] prdata, mem_addr, mem_data, base_wb_data, r, s;
    logic        pready, pslverr, mem_req, mem_ack, base_wb, irq, e;
    logic [3:0]  mem_be;
    int          n_errors  = 0;
    int          checks    = 0;
    int          cyc       = 0;
    swre_exp_t   exp_q[$];
    logic [31:0] wb_q[$];

    always #4 pclk = ~pclk;

    swre_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .resv_load(resv_load), .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_be(mem_be), .mem_ack(mem_ack), .base_wb(base_wb), .base_wb_data(base_wb_data),
        .irq(irq)
    );
    swre_mem_model u_mem (
        .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .delay_cyc(delay_cyc),
        .mem_ack(mem_ack)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task conclude;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task bad(input string m);
        n_errors++;
        $display("Error %0t: %s", $time, m);
    endtask : bad

    task cmp_w(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
            bad($sformatf("word got %h expected %h", got, exp));
    endtask : cmp_w

    task cmp_wr(input swre_exp_t x);
        checks++;
        if ({mem_addr, mem_data & x.dm, mem_be} !== {x.a, x.d & x.dm, x.be})
            bad($sformatf("store %h %h %h expected %h %h", mem_addr, mem_data, mem_be, x.a, x.d));
    endtask : cmp_wr

    task push(input logic [31:0] a, input logic [31:0] d, input logic [31:0] dm,
              input logic [3:0] be);
        exp_q.push_back('{a, d, dm, be});
    endtask : push

    // one idle cycle between transfers keeps every drive to one per step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task run(input logic [31:0] insn, input logic [31:0] b, input logic [31:0] x,
             input logic [7:0] c, input logic [5:0] ei);
        apb(1'b1, REG_INSN, insn);
        apb(1'b1, REG_SRC, s);
        apb(1'b1, REG_BASE, b);
        apb(1'b1, REG_INDEX, x);
        apb(1'b1, REG_IRQ_ST, 32'h3f);
        delay_cyc <= 8'($urandom_range(3, 0));
        apb(1'b1, REG_CTRL, {24'h0, c | 8'h01});
        do apb(1'b0, REG_STAT, 32'h0); while (r[5] !== 1'b0);
        apb(1'b0, REG_IRQ_ST, 32'h0);
        cmp_w(r, {26'h0, ei});
        cmp_w({31'h0, irq}, {31'h0, |(ei & mk)});
        s = $urandom();
    endtask : run

    task chk_stat(input logic [4:0] ex);
        apb(1'b0, REG_STAT, 32'h0);
        cmp_w({27'h0, r[4:0]}, {27'h0, ex});
    endtask : chk_stat

    task resv;
        @(posedge pclk);
        resv_load <= 1'b1;
        @(posedge pclk);
        resv_load <= 1'b0;
    endtask : resv

    function automatic logic [31:0] xf(input logic [9:0] xo, input logic [4:0] a, input logic rc);
        return {OPC_EXT, 5'h04, a, 5'h06, xo, rc};
    endfunction : xf

    function automatic logic [31:0] df(input logic [5:0] op, input logic [4:0] a,
                                       input logic [15:0] d);
        return {op, 5'h04, a, d};
    endfunction : df

    // ------------------------------------------------------------------
    // output watcher
    // ------------------------------------------------------------------
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad("timeout");
            conclude();
        end
        if (mem_req === 1'b1 && mem_ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                bad("unexpected store");
            else
                cmp_wr(exp_q.pop_front());
        end
        if (base_wb === 1'b1)
        begin
            if (wb_q.size() == 0)
                bad("unexpected base write back");
            else
                cmp_w(base_wb_data, wb_q.pop_front());
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h2e6cb45e));
        s = $urandom();
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i <= 36; i += 4)
        begin
            apb(1'b0, 8'(i), 32'h0);
            cmp_w(r, RST_ZERO);
        end
        apb(1'b0, 8'h40, 32'h0);
        cmp_w({31'h0, e}, 32'h1);
        cmp_w(r, 32'h0);
        mk = 6'h3f;
        apb(1'b1, REG_IRQ_MK, {26'h0, mk});
        push(32'h0000_0ff8, s, '1, 4'hf);
        run(df(OPC_STW, 5'h03, 16'hfff8), 32'h1000, 32'h0, 8'h00, 6'h01);
        push(32'h0000_0010, s, '1, 4'hf);
        run(df(OPC_STW, 5'h00, 16'h0010), 32'h5555_0000, 32'h0, 8'h00, 6'h01);
        push(32'h0000_2010, s, '1, 4'hf);
        wb_q.push_back(32'h0000_2010);
        run(df(OPC_STW_UPD, 5'h05, 16'h0010), 32'h2000, 32'h0, 8'h00, 6'h01);
        push(32'h0000_0300, s, '1, 4'hf);
        run(xf(XO_STW_IDX, 5'h00, 1'b0), 32'h7000, 32'h300, 8'h00, 6'h01);
        push(32'h0000_4044, s, '1, 4'hf);
        wb_q.push_back(32'h0000_4044);
        run(xf(XO_STWUX, 5'h02, 1'b0), 32'h4000, 32'h44, 8'h00, 6'h01);
        push(32'h0000_0108, {s[7:0], s[15:8], s[23:16], s[31:24]}, '1, 4'hf);
        run(xf(XO_STWBRX, 5'h01, 1'b1), 32'h100, 32'h8, 8'h00, 6'h01);
        push(32'h0000_0108, s, '1, 4'hf);
        run(xf(XO_STWBRX, 5'h01, 1'b1), 32'h100, 32'h8, 8'h08, 6'h01);
        push(32'h0000_0100, 32'h0, 32'h0, 4'h1);
        push(32'h0000_0104, 32'h0, 32'h0, 4'he);
        run(xf(XO_STW_IDX, 5'h01, 1'b0), 32'h103, 32'h0, 8'h00, 6'h01);
        chk_stat(5'h00);
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h200, 32'h4, 8'hd0, 6'h01);
        chk_stat(5'h01);
        resv();
        chk_stat(5'h11);
        push(32'h0000_0204, s, '1, 4'hf);
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h200, 32'h4, 8'h00, 6'h01);
        chk_stat(5'h02);
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h200, 32'h4, 8'h20, 6'h05);
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h202, 32'h0, 8'h04, 6'h03);
        resv();
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h200, 32'h4, 8'h20, 6'h05);
        resv();
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h202, 32'h0, 8'h04, 6'h03);
        resv();
        push(32'h0000_0200, 32'h0, 32'h0, 4'h3);
        push(32'h0000_0204, 32'h0, 32'h0, 4'hc);
        run(xf(XO_STWCX, 5'h01, 1'b1), 32'h202, 32'h0, 8'h00, 6'h01);
        chk_stat(5'h02);
        run(df(OPC_STW_UPD, 5'h00, 16'h0010), 32'h0, 32'h0, 8'h00, 6'h21);
        mk = 6'h00;
        apb(1'b1, REG_IRQ_MK, {26'h0, mk});
        push(32'h0000_0ff8, s, '1, 4'hf);
        run(df(OPC_STW, 5'h03, 16'hfff8), 32'h1000, 32'h0, 8'h00, 6'h01);
        apb(1'b1, REG_IRQ_ST, 32'h3f);
        apb(1'b0, REG_IRQ_ST, 32'h0);
        cmp_w(r, 32'h0);
        cmp_w(32'(exp_q.size()), 32'h0);
        cmp_w(32'(wb_q.size()), 32'h0);
        conclude();
    end
endmodule : tb
